//--- shared/pxb_defs.vh
`ifndef PXB_DEFS_VH
`define PXB_DEFS_VH
// ---------------------------------------------------------------
// Register addresses in the special-function space
// ---------------------------------------------------------------
`define PXB_ADDR_ROUTE_TWO  8'hc7
`define PXB_ADDR_ROUTE_ZERO 8'he1
`define PXB_ADDR_IRQ_CFG    8'he4
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PXB_RST_ROUTE_TWO   8'h00
`define PXB_RST_ROUTE_ZERO  8'h00
`define PXB_RST_IRQ_CFG     8'h00
// ---------------------------------------------------------------
// Route control zero fields
// ---------------------------------------------------------------
`define PXB_B_CMPB_ASYNC    7
`define PXB_B_CMPB_SYNC     6
`define PXB_B_CMPA_ASYNC    5
`define PXB_B_CMPA_SYNC     4
`define PXB_B_TWOWIRE       3
`define PXB_B_SPERIPH       2
`define PXB_B_FIELDBUS      1
`define PXB_B_ASERIAL       0
// ---------------------------------------------------------------
// Route control two fields
// ---------------------------------------------------------------
`define PXB_B_PULLUP_DIS    7
`define PXB_B_MATRIX_EN     6
`define PXB_B_LOCALNET      0
`define PXB_RT2_WMASK       8'hc1
// ---------------------------------------------------------------
// Interrupt pin config fields
// ---------------------------------------------------------------
`define PXB_B_IRQB_POL      7
`define PXB_F_IRQB_SEL      6:4
`define PXB_B_IRQA_POL      3
`define PXB_F_IRQA_SEL      2:0
// ---------------------------------------------------------------
// Fixed pins, port 0 index
// ---------------------------------------------------------------
`define PXB_PIN_ASER_TX     4
`define PXB_PIN_ASER_RX     5
`define PXB_PIN_FBUS_TX     6
`define PXB_PIN_FBUS_RX     7
`endif

//--- rtl/pxb_crossbar.v
// Summary of operation
// [RULE1] Comparator B async/sync outputs routed by bits 7,6
// [RULE2] Comparator A async/sync outputs routed by bits 5,4
// [RULE3] Bit 3 routes two-wire bus signals
// [RULE4] Bit 2 routes SPI, three or four pins
// [RULE5] Bit 1 routes CAN to P0.6/P0.7
// [RULE6] Bit 0 routes serial TX/RX to P0.4/P0.5
// [RULE7] Pull-up disable bit turns off weak pull-ups
// [RULE8] Matrix enable bit gates the whole crossbar
// [RULE9] Software writes zeros to reserved bits 5:1
// [RULE10] Local-net bit routes LIN TX/RX to pins
// [RULE11] Bit 7 sets interrupt B polarity
// [RULE12] Bits 6:4 pick port-1 pin for interrupt B
// [RULE13] Bit 3 sets interrupt A polarity
// [RULE14] Bits 2:0 pick port-1 pin for interrupt A
// [RULE15] Interrupt inputs watch pins without disturbing routing
// [RULE16] Skipped pins never get a peripheral
// [RULE17] All three registers clear on reset
// [RULE18] Fixed-priority combinational assignment to free pins
`timescale 1ns/1ns
`include "pxb_defs.vh"
module pxb_crossbar #(
   parameter NPINS = 16
) (
   input  wire             REF_CLK,
   input  wire             RESET,
   input  wire [7:0]       SFR_ADDR,
   input  wire             SFR_WR,
   input  wire             SFR_RD,
   input  wire [7:0]       SFR_WDATA,
   output reg  [7:0]       SFR_RDATA,
   input  wire [NPINS-1:0] PIN_SKIP,
   input  wire [NPINS-1:0] PIN_ANALOG,
   input  wire [NPINS-1:0] PIN_IN,
   output wire [NPINS-1:0] PIN_OUT,
   output wire [NPINS-1:0] PIN_OE,
   output wire [NPINS-1:0] PIN_PULLUP,
   input  wire             TWOWIRE_SDA_OUT,
   input  wire             TWOWIRE_SCL_OUT,
   output wire             TWOWIRE_SDA_IN,
   output wire             TWOWIRE_SCL_IN,
   input  wire             SPI_4WIRE,
   input  wire             SPI_SCK_OUT,
   input  wire             SPI_SCK_OE,
   input  wire             SPI_MOSI_OUT,
   input  wire             SPI_MOSI_OE,
   input  wire             SPI_MISO_OUT,
   input  wire             SPI_MISO_OE,
   input  wire             SPI_NSS_OUT,
   input  wire             SPI_NSS_OE,
   output wire             SPI_SCK_IN,
   output wire             SPI_MOSI_IN,
   output wire             SPI_MISO_IN,
   output wire             SPI_NSS_IN,
   input  wire             FIELD_BUS_TX,
   output wire             FIELD_BUS_RX,
   input  wire             ASYNC_SERIAL_TX,
   output wire             ASYNC_SERIAL_RX,
   input  wire             CMP_A_OUT,
   input  wire             CMP_A_ASYNC_OUT,
   input  wire             CMP_B_OUT,
   input  wire             CMP_B_ASYNC_OUT,
   input  wire             LOCAL_NET_TX,
   output wire             LOCAL_NET_RX,
   output wire             EXT_IRQ_A,
   output wire             EXT_IRQ_B
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg [7:0] route_zero_q;
   reg [7:0] route_two_q;
   reg [7:0] irq_cfg_q;

   always @(posedge REF_CLK) begin
      if (RESET) begin
         route_zero_q <= `PXB_RST_ROUTE_ZERO; // RULE17
         route_two_q  <= `PXB_RST_ROUTE_TWO; // RULE17
         irq_cfg_q    <= `PXB_RST_IRQ_CFG; // RULE17
      end else if (SFR_WR) begin
         if (SFR_ADDR == `PXB_ADDR_ROUTE_ZERO)
            route_zero_q <= SFR_WDATA;
         if (SFR_ADDR == `PXB_ADDR_ROUTE_TWO)
            route_two_q <= SFR_WDATA & `PXB_RT2_WMASK; // RULE9
         if (SFR_ADDR == `PXB_ADDR_IRQ_CFG)
            irq_cfg_q <= SFR_WDATA;
      end
   end

   // Read data is registered; unmapped addresses read zero
   always @(posedge REF_CLK) begin
      if (RESET) begin
         SFR_RDATA <= 8'h00;
      end else if (SFR_RD) begin
         case (SFR_ADDR)
            `PXB_ADDR_ROUTE_ZERO: SFR_RDATA <= route_zero_q;
            `PXB_ADDR_ROUTE_TWO:  SFR_RDATA <= route_two_q;
            `PXB_ADDR_IRQ_CFG:    SFR_RDATA <= irq_cfg_q;
            default:              SFR_RDATA <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   reg [NPINS-1:0] pin_meta_q;
   reg [NPINS-1:0] pin_sync_q;
   always @(posedge REF_CLK) begin
      if (RESET) begin
         pin_meta_q <= {NPINS{1'b0}};
         pin_sync_q <= {NPINS{1'b0}};
      end else begin
         pin_meta_q <= PIN_IN;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // Enables
   // ---------------------------------------------------------------
   wire xen = route_two_q[`PXB_B_MATRIX_EN]; // RULE8
   wire en_aser  = xen & route_zero_q[`PXB_B_ASERIAL]; // RULE6
   wire en_fbus  = xen & route_zero_q[`PXB_B_FIELDBUS]; // RULE5
   wire en_spi   = xen & route_zero_q[`PXB_B_SPERIPH]; // RULE4
   wire en_twow  = xen & route_zero_q[`PXB_B_TWOWIRE]; // RULE3
   wire en_cmpa  = xen & route_zero_q[`PXB_B_CMPA_SYNC]; // RULE2
   wire en_cmpaa = xen & route_zero_q[`PXB_B_CMPA_ASYNC]; // RULE2
   wire en_cmpb  = xen & route_zero_q[`PXB_B_CMPB_SYNC]; // RULE1
   wire en_cmpba = xen & route_zero_q[`PXB_B_CMPB_ASYNC]; // RULE1
   wire en_lin   = xen & route_two_q[`PXB_B_LOCALNET]; // RULE10

   // ---------------------------------------------------------------
   // Priority assignment
   // ---------------------------------------------------------------
   // Signal slots in priority order. Serial and field bus own fixed
   // pins; the rest take the lowest free non-skipped pin in turn.
   localparam NSIG = 12;
   localparam [3:0] SL_SDA     = 4'h1;
   localparam [3:0] SL_SCL     = 4'h2;
   localparam [3:0] SL_SCK     = 4'h3;
   localparam [3:0] SL_MISO    = 4'h4;
   localparam [3:0] SL_MOSI    = 4'h5;
   localparam [3:0] SL_NSS     = 4'h6;
   localparam [3:0] SL_CMPA    = 4'h7;
   localparam [3:0] SL_CMPA_AS = 4'h8;
   localparam [3:0] SL_CMPB    = 4'h9;
   localparam [3:0] SL_CMPB_AS = 4'ha;
   localparam [3:0] SL_LIN_TX  = 4'hb;
   localparam [3:0] SL_LIN_RX  = 4'hc;
   reg  [NSIG-1:0] sig_en;
   reg  [NSIG-1:0] sig_out;
   reg  [NSIG-1:0] sig_oe;
   reg  [NPINS-1:0] pin_out_d;
   reg  [NPINS-1:0] pin_oe_d;
   reg  [NPINS-1:0] pin_used;
   reg  [3:0]       pin_sig [0:NPINS-1];
   reg  [NPINS-1:0] pin_has;
   reg              placed;
   integer          s;
   integer          p;

   always @* begin
      sig_en  = {NSIG{1'b0}};
      sig_out = {NSIG{1'b0}};
      sig_oe  = {NSIG{1'b0}};
      sig_en[SL_SDA]      = en_twow; // RULE3
      sig_en[SL_SCL]      = en_twow; // RULE3
      sig_en[SL_SCK]      = en_spi; // RULE4
      sig_en[SL_MISO]     = en_spi; // RULE4
      sig_en[SL_MOSI]     = en_spi; // RULE4
      sig_en[SL_NSS]      = en_spi & SPI_4WIRE; // RULE4
      sig_en[SL_CMPA]     = en_cmpa; // RULE2
      sig_en[SL_CMPA_AS]  = en_cmpaa; // RULE2
      sig_en[SL_CMPB]     = en_cmpb; // RULE1
      sig_en[SL_CMPB_AS]  = en_cmpba; // RULE1
      sig_en[SL_LIN_TX]   = en_lin; // RULE10
      sig_out[SL_SDA]     = TWOWIRE_SDA_OUT;
      sig_out[SL_SCL]     = TWOWIRE_SCL_OUT;
      sig_out[SL_SCK]     = SPI_SCK_OUT;
      sig_out[SL_MISO]    = SPI_MISO_OUT;
      sig_out[SL_MOSI]    = SPI_MOSI_OUT;
      sig_out[SL_NSS]     = SPI_NSS_OUT;
      sig_out[SL_CMPA]    = CMP_A_OUT;
      sig_out[SL_CMPA_AS] = CMP_A_ASYNC_OUT;
      sig_out[SL_CMPB]    = CMP_B_OUT;
      sig_out[SL_CMPB_AS] = CMP_B_ASYNC_OUT;
      sig_out[SL_LIN_TX]  = LOCAL_NET_TX;
      // Two-wire pins are open drain: drive only a low
      sig_oe[SL_SDA]      = ~TWOWIRE_SDA_OUT;
      sig_oe[SL_SCL]      = ~TWOWIRE_SCL_OUT;
      sig_oe[SL_SCK]      = SPI_SCK_OE;
      sig_oe[SL_MISO]     = SPI_MISO_OE;
      sig_oe[SL_MOSI]     = SPI_MOSI_OE;
      sig_oe[SL_NSS]      = SPI_NSS_OE;
      sig_oe[SL_CMPA]     = 1'b1;
      sig_oe[SL_CMPA_AS]  = 1'b1;
      sig_oe[SL_CMPB]     = 1'b1;
      sig_oe[SL_CMPB_AS]  = 1'b1;
      sig_oe[SL_LIN_TX]   = 1'b1;
      pin_used  = {NPINS{1'b0}};
      pin_has   = {NPINS{1'b0}};
      pin_out_d = {NPINS{1'b0}};
      pin_oe_d  = {NPINS{1'b0}};
      for (p = 0; p < NPINS; p = p + 1)
         pin_sig[p] = 4'h0;
      // Fixed pins are claimed first
      if (en_aser && !PIN_SKIP[`PXB_PIN_ASER_TX]) begin // RULE16
         pin_used[`PXB_PIN_ASER_TX] = 1'b1;
         pin_out_d[`PXB_PIN_ASER_TX] = ASYNC_SERIAL_TX; // RULE6
         pin_oe_d[`PXB_PIN_ASER_TX] = 1'b1;
      end
      if (en_aser && !PIN_SKIP[`PXB_PIN_ASER_RX])
         pin_used[`PXB_PIN_ASER_RX] = 1'b1;
      if (en_fbus && !PIN_SKIP[`PXB_PIN_FBUS_TX]) begin
         pin_used[`PXB_PIN_FBUS_TX] = 1'b1;
         pin_out_d[`PXB_PIN_FBUS_TX] = FIELD_BUS_TX; // RULE5
         pin_oe_d[`PXB_PIN_FBUS_TX] = 1'b1;
      end
      if (en_fbus && !PIN_SKIP[`PXB_PIN_FBUS_RX])
         pin_used[`PXB_PIN_FBUS_RX] = 1'b1;
      // Each slot walks to the next free pin; LIN takes two pins
      for (s = 1; s < NSIG; s = s + 1) begin // RULE18
         placed = 1'b0;
         for (p = 0; p < NPINS; p = p + 1) begin
            if (sig_en[s] && !placed && !pin_used[p] && !PIN_SKIP[p]) begin // RULE16
               placed = 1'b1;
               pin_used[p] = 1'b1;
               pin_has[p] = 1'b1;
               pin_sig[p] = s[3:0];
               pin_out_d[p] = sig_out[s];
               pin_oe_d[p] = sig_oe[s];
            end
         end
      end
      placed = 1'b0;
      for (p = 0; p < NPINS; p = p + 1) begin
         if (en_lin && !placed && !pin_used[p] && !PIN_SKIP[p]) begin // RULE10
            placed = 1'b1;
            pin_used[p] = 1'b1;
            pin_has[p] = 1'b1;
            pin_sig[p] = SL_LIN_RX;
         end
      end
   end

   // Input return paths: take value of the pin owning each slot
   reg [12:0] sig_in;
   integer    k;
   always @* begin
      sig_in = {13{1'b1}};
      for (k = 0; k < NPINS; k = k + 1) begin
         if (pin_has[k])
            sig_in[pin_sig[k]] = pin_sync_q[k];
      end
   end

   assign PIN_OUT = pin_out_d;
   assign PIN_OE  = pin_oe_d;
   // Analog pins never get a pull-up
   assign PIN_PULLUP = route_two_q[`PXB_B_PULLUP_DIS] ? {NPINS{1'b0}} : ~PIN_ANALOG; // RULE7

   assign TWOWIRE_SDA_IN  = sig_in[SL_SDA]; // RULE3
   assign TWOWIRE_SCL_IN  = sig_in[SL_SCL];
   assign SPI_SCK_IN      = sig_in[SL_SCK]; // RULE4
   assign SPI_MISO_IN     = sig_in[SL_MISO];
   assign SPI_MOSI_IN     = sig_in[SL_MOSI];
   assign SPI_NSS_IN      = sig_in[SL_NSS];
   assign LOCAL_NET_RX    = sig_in[SL_LIN_RX]; // RULE10
   // Unrouted receivers idle high, the serial line's rest level
   assign ASYNC_SERIAL_RX = (en_aser && !PIN_SKIP[`PXB_PIN_ASER_RX]) ?
                            pin_sync_q[`PXB_PIN_ASER_RX] : 1'b1; // RULE6
   assign FIELD_BUS_RX    = (en_fbus && !PIN_SKIP[`PXB_PIN_FBUS_RX]) ?
                            pin_sync_q[`PXB_PIN_FBUS_RX] : 1'b1; // RULE5

   // ---------------------------------------------------------------
   // External interrupt pin select
   // ---------------------------------------------------------------
   // Port 1 is pins 15:8; reads only, so routing is untouched
   wire [7:0] port1 = pin_sync_q[15:8]; // RULE15
   reg irq_a_raw;
   reg irq_b_raw;
   // Plain selector per input; the skip setting has no say over it
   always @* begin
      case (irq_cfg_q[`PXB_F_IRQA_SEL]) // RULE14
         3'h0: irq_a_raw = port1[0];
         3'h1: irq_a_raw = port1[1];
         3'h2: irq_a_raw = port1[2];
         3'h3: irq_a_raw = port1[3];
         3'h4: irq_a_raw = port1[4];
         3'h5: irq_a_raw = port1[5];
         3'h6: irq_a_raw = port1[6];
         3'h7: irq_a_raw = port1[7];
         default: irq_a_raw = port1[0];
      endcase
      case (irq_cfg_q[`PXB_F_IRQB_SEL]) // RULE12
         3'h0: irq_b_raw = port1[0];
         3'h1: irq_b_raw = port1[1];
         3'h2: irq_b_raw = port1[2];
         3'h3: irq_b_raw = port1[3];
         3'h4: irq_b_raw = port1[4];
         3'h5: irq_b_raw = port1[5];
         3'h6: irq_b_raw = port1[6];
         3'h7: irq_b_raw = port1[7];
         default: irq_b_raw = port1[0];
      endcase
   end
   // Outputs are active high once polarity is applied
   assign EXT_IRQ_A = irq_cfg_q[`PXB_B_IRQA_POL] ? irq_a_raw : ~irq_a_raw; // RULE13
   assign EXT_IRQ_B = irq_cfg_q[`PXB_B_IRQB_POL] ? irq_b_raw : ~irq_b_raw; // RULE11

endmodule

//--- bench/pxb_periph_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Peripheral drive pattern
// ----------------------------------------
module pxb_periph_model (
   input  wire        clk,
   input  wire        rst,
   output reg  [16:0] drv_q
);
   // Odd step flips bit 0 every cycle and most others often, so a stale or swapped route shows
   always @(posedge clk) begin
      if (rst) begin
         drv_q <= 17'h00000;
      end else begin
         drv_q <= drv_q + 17'h0b5a7;
      end
   end
endmodule

//--- bench/pxb_crossbar_properties.sv
`timescale 1ns/1ns
module pxb_crossbar_props #(
   parameter NPINS = 16
) (
   input wire             REF_CLK,
   input wire             RESET,
   input wire [7:0]       SFR_ADDR,
   input wire             SFR_WR,
   input wire             SFR_RD,
   input wire [7:0]       SFR_WDATA,
   input wire [7:0]       SFR_RDATA,
   input wire [NPINS-1:0] PIN_SKIP,
   input wire [NPINS-1:0] PIN_ANALOG,
   input wire [NPINS-1:0] PIN_IN,
   input wire [NPINS-1:0] PIN_OUT,
   input wire [NPINS-1:0] PIN_OE,
   input wire [NPINS-1:0] PIN_PULLUP,
   input wire             FIELD_BUS_TX,
   input wire             ASYNC_SERIAL_TX,
   input wire             ASYNC_SERIAL_RX,
   input wire             EXT_IRQ_A,
   input wire             EXT_IRQ_B
);
   // ----------------------------------------
   // Shadow registers and pin synchroniser
   // ----------------------------------------
   reg [7:0]       two_q;
   reg [7:0]       zero_q;
   reg [7:0]       cfg_q;
   reg [NPINS-1:0] s1_q;
   reg [NPINS-1:0] s2_q;
   always @(posedge REF_CLK) begin
      if (RESET) begin
         two_q <= 8'h00;
         zero_q <= 8'h00;
         cfg_q <= 8'h00;
         s1_q <= {NPINS{1'b0}};
         s2_q <= {NPINS{1'b0}};
      end else begin
         s1_q <= PIN_IN;
         s2_q <= s1_q;
         if (SFR_WR && SFR_ADDR == 8'hc7) two_q <= SFR_WDATA & 8'hc1;
         if (SFR_WR && SFR_ADDR == 8'he1) zero_q <= SFR_WDATA;
         if (SFR_WR && SFR_ADDR == 8'he4) cfg_q <= SFR_WDATA;
      end
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   AST_RST_IDLE: assert property ($fell(RESET) |-> PIN_OE == 0 && PIN_PULLUP == ~PIN_ANALOG)
      else $error("pins not idle after reset");
   AST_SKIP_FREE: assert property ((PIN_OE & PIN_SKIP) == 0)
      else $error("skipped pin driven");
   AST_OFF_IDLE: assert property (!two_q[6] |-> PIN_OE == 0)
      else $error("pin driven with crossbar off");
   AST_PULLUP: assert property (PIN_PULLUP == (two_q[7] ? {NPINS{1'b0}} : ~PIN_ANALOG))
      else $error("pull-up mismatch");
   AST_RSV_READ: assert property (SFR_RD && SFR_ADDR == 8'hc7 |=> SFR_RDATA[5:1] == 5'h00)
      else $error("reserved bits read nonzero");
   AST_ASER_TX: assert property (two_q[6] && zero_q[0] && !PIN_SKIP[4] |->
      PIN_OE[4] && PIN_OUT[4] == ASYNC_SERIAL_TX)
      else $error("serial tx not on pin 4");
   AST_ASER_RX: assert property (two_q[6] && zero_q[0] && !PIN_SKIP[5] |-> ASYNC_SERIAL_RX == s2_q[5])
      else $error("serial rx not from pin 5");
   AST_FBUS_TX: assert property (two_q[6] && zero_q[1] && !PIN_SKIP[6] |->
      PIN_OE[6] && PIN_OUT[6] == FIELD_BUS_TX)
      else $error("field bus tx not on pin 6");
   AST_IRQ_A: assert property (EXT_IRQ_A == (s2_q[8 + cfg_q[2:0]] ~^ cfg_q[3]))
      else $error("irq a mismatch");
   AST_IRQ_B: assert property (EXT_IRQ_B == (s2_q[8 + cfg_q[6:4]] ~^ cfg_q[7]))
      else $error("irq b mismatch");
endmodule
bind pxb_crossbar pxb_crossbar_props #(.NPINS(NPINS)) u_props (.*);

//--- bench/pxb_crossbar_tb.sv
`timescale 1ns/1ns
`define CHK(n, g, e) begin \
   checks++; \
   if ((g) !== (e)) begin \
      err_total++; \
      $display("Error %s exp %h got %h", n, e, g); \
   end \
end
module pxb_crossbar_tb;
   reg         clk;
   reg         rst;
   reg         wr_s;
   reg         rd_s;
   reg         four;
   reg  [7:0]  addr;
   reg  [7:0]  wdat;
   reg  [15:0] skip;
   reg  [15:0] ana;
   reg  [15:0] ext;
   wire [7:0]  rdat;
   wire [15:0] p_out;
   wire [15:0] p_oe;
   wire [15:0] p_pu;
   wire [16:0] drv;
   wire        fb_rx;
   wire        as_rx;
   wire        ln_rx;
   wire        irq_a;
   wire        irq_b;
   wire        sda_in;
   wire        scl_in;
   wire        sck_in;
   wire        mosi_in;
   wire        miso_in;
   wire        nss_in;
   reg  [15:0] pin_d1;
   reg  [15:0] pin_d2;
   wire [15:0] pin = (p_oe & p_out) | (~p_oe & ext);
   integer     err_total = 0;
   integer     checks = 0;
   integer     n;
   pxb_periph_model u_per (.clk(clk), .rst(rst), .drv_q(drv));
   pxb_crossbar dut (.REF_CLK(clk), .RESET(rst), .SFR_ADDR(addr), .SFR_WR(wr_s), .SFR_RD(rd_s),
      .SFR_WDATA(wdat), .SFR_RDATA(rdat), .PIN_SKIP(skip), .PIN_ANALOG(ana), .PIN_IN(pin), .PIN_OUT(p_out),
      .PIN_OE(p_oe), .PIN_PULLUP(p_pu), .TWOWIRE_SDA_OUT(drv[0]), .TWOWIRE_SCL_OUT(drv[1]),
      .TWOWIRE_SDA_IN(sda_in), .TWOWIRE_SCL_IN(scl_in), .SPI_4WIRE(four), .SPI_SCK_OUT(drv[2]),
      .SPI_SCK_OE(drv[3]), .SPI_MOSI_OUT(drv[4]), .SPI_MOSI_OE(drv[5]), .SPI_MISO_OUT(drv[6]),
      .SPI_MISO_OE(drv[7]), .SPI_NSS_OUT(drv[8]), .SPI_NSS_OE(drv[9]), .SPI_SCK_IN(sck_in),
      .SPI_MOSI_IN(mosi_in), .SPI_MISO_IN(miso_in), .SPI_NSS_IN(nss_in),
      .FIELD_BUS_TX(drv[10]), .FIELD_BUS_RX(fb_rx), .ASYNC_SERIAL_TX(drv[11]), .ASYNC_SERIAL_RX(as_rx),
      .CMP_A_OUT(drv[12]), .CMP_A_ASYNC_OUT(drv[13]), .CMP_B_OUT(drv[14]), .CMP_B_ASYNC_OUT(drv[15]),
      .LOCAL_NET_TX(drv[16]), .LOCAL_NET_RX(ln_rx), .EXT_IRQ_A(irq_a), .EXT_IRQ_B(irq_b));
   // Pad levels two edges back, the age at which receive paths see them
   always @(posedge clk) begin
      pin_d1 <= pin;
      pin_d2 <= pin_d1;
   end
   // ----------------------------------------
   // Register access and pin checks
   // ----------------------------------------
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdat <= d;
         wr_s <= 1'b1;
         @(posedge clk);
         wr_s <= 1'b0;
         #1;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk);
         addr <= a;
         rd_s <= 1'b1;
         @(posedge clk);
         rd_s <= 1'b0;
         #1;
         `CHK("sfr_rdata", rdat, e)
      end
   endtask
   task pc(input integer i, input o, input v);
      begin
         `CHK("pin_oe", p_oe[i], o)
         if (o) `CHK("pin_out", p_out[i], v)
      end
   endtask
   task wt(input integer k);
      begin
         repeat (k) @(posedge clk);
         #1;
      end
   endtask
   task stop_test;
      begin
         if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      stop_test;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      wr_s = 1'b0;
      rd_s = 1'b0;
      four = 1'b0;
      addr = 8'h00;
      wdat = 8'h00;
      skip = 16'h0000;
      ana = 16'h0f00;
      ext = 16'h0000;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(8'hc7, 8'h00);
      rd(8'he1, 8'h00);
      rd(8'he4, 8'h00);
      rd(8'h5a, 8'h00);
      `CHK("pin_pullup", p_pu, ~ana)
      `CHK("twowire_sda_in", sda_in, 1'b1)
      `CHK("spi_sck_in", sck_in, 1'b1)
      wr(8'hc7, 8'hc1);
      rd(8'hc7, 8'hc1);
      `CHK("pin_pullup", p_pu, 16'h0000)
      wr(8'hc7, 8'h40);
      wr(8'he1, 8'h03);
      pc(4, 1'b1, drv[11]);
      pc(6, 1'b1, drv[10]);
      wt(3);
      `CHK("serial_rx", as_rx, 1'b0)
      `CHK("fieldbus_rx", fb_rx, 1'b0)
      @(posedge clk);
      skip <= 16'h0030;
      wt(1);
      pc(4, 1'b0, 1'b0);
      `CHK("serial_rx", as_rx, 1'b1)
      @(posedge clk);
      skip <= 16'h0000;
      wr(8'hc7, 8'h00);
      `CHK("pin_oe", p_oe, 16'h0000)
      `CHK("fieldbus_rx", fb_rx, 1'b1)
      wr(8'hc7, 8'h40);
      wr(8'he1, 8'h08);
      pc(0, ~drv[0], 1'b0);
      pc(1, ~drv[1], 1'b0);
      wr(8'he1, 8'h04);
      pc(0, drv[3], drv[2]);
      pc(1, drv[7], drv[6]);
      pc(2, drv[5], drv[4]);
      pc(3, 1'b0, 1'b0);
      @(posedge clk);
      four <= 1'b1;
      wt(1);
      pc(3, drv[9], drv[8]);
      `CHK("spi_sck_in", sck_in, pin_d2[0])
      `CHK("spi_miso_in", miso_in, pin_d2[1])
      `CHK("spi_mosi_in", mosi_in, pin_d2[2])
      `CHK("spi_nss_in", nss_in, pin_d2[3])
      wr(8'he1, 8'hf0);
      pc(0, 1'b1, drv[12]);
      pc(1, 1'b1, drv[13]);
      pc(2, 1'b1, drv[14]);
      pc(3, 1'b1, drv[15]);
      `CHK("spi_sck_in", sck_in, 1'b1)
      wr(8'he1, 8'h00);
      wr(8'hc7, 8'h41);
      pc(0, 1'b1, drv[16]);
      pc(1, 1'b0, 1'b0);
      wt(3);
      `CHK("lin_rx", ln_rx, 1'b0)
      wr(8'hc7, 8'h40);
      `CHK("lin_rx", ln_rx, 1'b1)
      @(posedge clk);
      skip <= 16'h00ff;
      wr(8'he1, 8'h08);
      wr(8'he4, 8'h08);
      pc(8, ~drv[0], 1'b0);
      `CHK("twowire_sda_in", sda_in, pin_d2[8])
      `CHK("twowire_scl_in", scl_in, pin_d2[9])
      @(posedge clk);
      skip <= 16'h0000;
      wr(8'he1, 8'h00);
      for (n = 0; n < 8; n = n + 1) begin
         @(posedge clk);
         ext <= 16'h0100 << n;
         wr(8'he4, {n[0], ~n[2:0], n[1], n[2:0]});
         wt(2);
         `CHK("irq_a", irq_a, n[1])
         `CHK("irq_b", irq_b, ~n[0])
      end
      stop_test;
   end
endmodule
